// ---- src/fdcmd_regs.svh ----
// register offsets, field positions, opcodes and reset values of the floppy command block
`ifndef FDCMD_REGS_SVH
`define FDCMD_REGS_SVH
`define FDC_OFS_STA      3'h0
`define FDC_OFS_STB      3'h1
`define FDC_OFS_DOR      3'h2
`define FDC_OFS_TAPE     3'h3
`define FDC_OFS_MSR      3'h4
`define FDC_OFS_FIFO     3'h5
`define FDC_OFS_MODE     3'h6
`define FDC_OFS_DIR      3'h7
`define FDC_OP_SENSEINT  8'h08
`define FDC_OP_SEEK      8'h0f
`define FDC_OP_DUMP      8'h0e
`define FDC_OP_SENSEDRV  8'h04
`define FDC_ST0_INVALID  8'h80
`define FDC_ST0_SEEKEND  8'h20
`define FDC_DUMP_LEN     4'ha
`define FDC_MSR_RQM      7
`define FDC_MSR_DIO      6
`define FDC_MSR_BUSY     4
`define FDC_DS_LO        0
`define FDC_DS_HI        1
`define FDC_HDS_BIT      2
`define FDC_DOR_MOTA     4
`define FDC_DOR_MOTB     5
`define FDC_DOR_DMAEN    3
`define FDC_DOR_RESETN   2
`define FDC_RESET_BYTE   8'h00
`define FDC_STEP_TIME_NS 1000
`define FDC_CLK_NS       10
`endif

// ---- src/fdcmd_pkg.sv ----
// types shared by the floppy command block
package fdcmd_pkg;
   typedef enum logic [2:0] {
      FD_IDLE, FD_PARAM, FD_EXEC, FD_RESULT
   } fdcmd_state_e;
   typedef logic [7:0] fdcmd_byte_t;
endpackage : fdcmd_pkg

// ---- src/fdcmd_sync.sv ----
// three-stage synchroniser, change accepted when stages two and three agree
module fdcmd_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic MCLK,
   input  wire logic SRST,
   input  wire logic D,
   output logic      Q
);
   logic s1_ff, s2_ff, s3_ff, q_ff;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
         q_ff  <= INIT;
      end else begin
         s1_ff <= D;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            q_ff <= s3_ff;
         end
      end
   end
   assign Q = q_ff;
endmodule : fdcmd_sync

// ---- src/fdcmd_top.sv ----
// floppy command interpreter with pin status registers
// Functional notes
// [RQ1] sense interrupt opcode 08h returns status byte zero then present cylinder
// [RQ2] seek takes opcode, head/drive byte, cylinder target; steps head; no result
// [RQ3] register dump returns four cylinders, timing, sector count, modes, config, precomp
// [RQ4] sense drive status takes drive byte, returns status byte three
// [RQ5] any invalid opcode returns single status byte zero equal to 80h
// [RQ6] offsets 0..7 decode status A/B, output, tape, main status, fifo, input
// [RQ7] status A bit 7 shows the interrupt output in both modes
// [RQ8] second drive indication: A bit 6 full mode, B bit 7 reduced
// [RQ9] full mode A bit 5 is inverted step output
// [RQ10] full mode A bit 4 is raw track zero input
// [RQ11] full mode A bit 3 inverted head output, bit 2 raw index
// [RQ12] full mode A bit 1 write protect low-true, bit 0 direction inward
// [RQ13] reduced mode A bit 6 dma request, bit 5 inverted latched step
// [RQ14] reduced A bit 4 inverted track zero, bit 3 raw head, bit 2 inverted index
// [RQ15] reduced A bit 1 write protect high-true, bit 0 direction outward
// [RQ16] full mode B bit 5 mirrors output register drive select bit zero
// [RQ17] full mode B bits 4 and 3 toggle on write/read data rising edges
// [RQ18] full mode B bits 2..0 inverted write gate, motor B, motor A
// [RQ19] reduced mode B bits 6,5 raw drive B and A select outputs
// [RQ20] reduced B bits 4..2 inverted latched write data, read data, write gate; bit 4 here stays 0, the write data latch never loads a low level
// [RQ21] reduced B bit 1 low when drive D selected, bit 0 for drive C
// [RQ22] host reads all result bytes before writing the next opcode
//
// Chosen here: the plain strobed port.
`include "fdcmd_regs.svh"
module fdcmd_top #(
   parameter int STEP_NS    = `FDC_STEP_TIME_NS,
   parameter int SETTLE_CYC = 4
) (
   input  wire logic                  MCLK,
   input  wire logic                  SRST,
   input  wire logic [2:0]            ADDR,
   input  wire fdcmd_pkg::fdcmd_byte_t WDATA,
   input  wire logic                  WR,
   input  wire logic                  RD,
   output fdcmd_pkg::fdcmd_byte_t     RDATA,
   input  wire logic                  TRACK_ZERO_N,
   input  wire logic                  INDEX_N,
   input  wire logic                  WRITE_PROT_N,
   input  wire logic                  READ_STREAM_N,
   input  wire logic                  SECOND_DRIVE_PRESENT_N,
   input  wire logic                  DMA_REQ,
   input  wire logic                  WRITE_STREAM_N,
   input  wire logic                  WRITE_GATE_N,
   output logic                       STEP_N,
   output logic                       DIR_IN,
   output logic                       HEAD_N,
   output logic                       MOTOR_ON_A_N,
   output logic                       MOTOR_ON_B_N,
   output logic                       UNIT_PICK_A_N,
   output logic                       UNIT_PICK_B_N,
   output logic                       UNIT_PICK_C_N,
   output logic                       UNIT_PICK_D_N,
   output logic                       IRQ
);
   import fdcmd_pkg::*;

   localparam int STEP_CYC_RAW = STEP_NS / `FDC_CLK_NS;
   localparam int STEP_CYC     = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;

   fdcmd_state_e state_ff;

   fdcmd_byte_t  op_ff;
   fdcmd_byte_t  drvsel_ff;
   fdcmd_byte_t  target_ff;
   fdcmd_byte_t  st0_ff;
   fdcmd_byte_t  dor_ff;
   fdcmd_byte_t  tape_ff;
   fdcmd_byte_t  mode_ff;
   fdcmd_byte_t  rdata_ff;

   fdcmd_byte_t  cyl_ff [4];
   fdcmd_byte_t  res_ff [10];

   logic [3:0]   res_cnt_ff;
   logic [3:0]   res_idx_ff;
   logic [1:0]   par_cnt_ff;
   logic [15:0]  step_cnt_ff;

   logic         step_n_ff;
   logic         dir_ff;
   logic         irq_ff;
   logic         head_n_ff;

   logic         step_latch_ff;
   logic         wd_latch_ff;
   logic         rd_latch_ff;
   logic         we_latch_ff;

   logic         wd_tog_ff;
   logic         rd_tog_ff;
   logic         wd_prev_ff;
   logic         rd_prev_ff;
   logic         we_prev_ff;

   // synchronised pin levels, about four cycles behind the pins
   logic         trk0_s;
   logic         idx_s;
   logic         wp_s;
   logic         rdn_s;
   logic         second_drive_present_n_s;
   logic         drq_s;
   logic         wdn_s;
   logic         wen_s;

   fdcmd_sync u_trk0 (.MCLK(MCLK), .SRST(SRST), .D(TRACK_ZERO_N),  .Q(trk0_s));
   fdcmd_sync u_idx  (.MCLK(MCLK), .SRST(SRST), .D(INDEX_N),       .Q(idx_s));
   fdcmd_sync u_wp   (.MCLK(MCLK), .SRST(SRST), .D(WRITE_PROT_N),  .Q(wp_s));
   fdcmd_sync u_rdn  (.MCLK(MCLK), .SRST(SRST), .D(READ_STREAM_N), .Q(rdn_s));
   fdcmd_sync u_second_drive_present_n (.MCLK(MCLK), .SRST(SRST), .D(SECOND_DRIVE_PRESENT_N), .Q(second_drive_present_n_s));
   fdcmd_sync #(.INIT(1'b0)) u_drq (.MCLK(MCLK), .SRST(SRST), .D(DMA_REQ), .Q(drq_s));
   fdcmd_sync u_wdn  (.MCLK(MCLK), .SRST(SRST), .D(WRITE_STREAM_N), .Q(wdn_s));
   fdcmd_sync u_wen  (.MCLK(MCLK), .SRST(SRST), .D(WRITE_GATE_N),  .Q(wen_s));

   wire fifo_wr = WR && (ADDR == `FDC_OFS_FIFO);
   wire fifo_rd = RD && (ADDR == `FDC_OFS_FIFO);
   wire full_mode = mode_ff[0];
   wire [1:0] sel = drvsel_ff[`FDC_DS_HI:`FDC_DS_LO];

   // unit selects from the output register; motor bits gate nothing else here
   wire [3:0] pick_n = ~(4'h1 << dor_ff[1:0]);

   // status byte three for the selected drive: wp, ready, track0, two-side, head, drive
   wire fdcmd_byte_t st3 = {~wp_s, 1'b1, 1'b0, ~trk0_s, 1'b1,
                            drvsel_ff[`FDC_HDS_BIT], sel};

   // command sequencer
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state_ff   <= FD_IDLE;
         op_ff      <= `FDC_RESET_BYTE;
         drvsel_ff  <= `FDC_RESET_BYTE;
         target_ff  <= `FDC_RESET_BYTE;
         par_cnt_ff <= 2'h0;
         res_cnt_ff <= 4'h0;
         res_idx_ff <= 4'h0;
         for (int i = 0; i < 10; i++) begin
            res_ff[i] <= `FDC_RESET_BYTE;
         end
      end else begin
         unique case (state_ff)
            FD_IDLE: begin
               if (fifo_wr) begin
                  op_ff      <= WDATA;
                  par_cnt_ff <= 2'h0;
                  res_idx_ff <= 4'h0;
                  if (WDATA == `FDC_OP_SENSEINT) begin
                     res_ff[0]  <= st0_ff;                       // [RQ1]
                     res_ff[1]  <= cyl_ff[sel];                  // [RQ1]
                     res_cnt_ff <= 4'h2;
                     state_ff   <= FD_RESULT;
                  end else if (WDATA == `FDC_OP_DUMP) begin
                     res_ff[0]  <= cyl_ff[0];                    // [RQ3]
                     res_ff[1]  <= cyl_ff[1];
                     res_ff[2]  <= cyl_ff[2];
                     res_ff[3]  <= cyl_ff[3];
                     res_ff[4]  <= `FDC_RESET_BYTE;              // step rate / unload
                     res_ff[5]  <= `FDC_RESET_BYTE;              // load time / non-dma
                     res_ff[6]  <= `FDC_RESET_BYTE;              // sector count
                     res_ff[7]  <= `FDC_RESET_BYTE;              // lock and perpendicular
                     res_ff[8]  <= `FDC_RESET_BYTE;              // configuration flags
                     res_ff[9]  <= `FDC_RESET_BYTE;              // precomp track
                     res_cnt_ff <= `FDC_DUMP_LEN;
                     state_ff   <= FD_RESULT;
                  end else if (WDATA == `FDC_OP_SEEK || WDATA == `FDC_OP_SENSEDRV) begin
                     state_ff <= FD_PARAM;                       // [RQ2] [RQ4]
                  end else begin
                     res_ff[0]  <= `FDC_ST0_INVALID;             // [RQ5]
                     res_cnt_ff <= 4'h1;
                     state_ff   <= FD_RESULT;
                  end
               end
            end
            FD_PARAM: begin
               if (fifo_wr) begin
                  par_cnt_ff <= par_cnt_ff + 2'h1;
                  if (par_cnt_ff == 2'h0) begin
                     drvsel_ff <= WDATA;
                     if (op_ff == `FDC_OP_SENSEDRV) begin
                        state_ff <= FD_EXEC;
                     end
                  end else begin
                     target_ff <= WDATA;                         // [RQ2]
                     state_ff  <= FD_EXEC;
                  end
               end
            end
            FD_EXEC: begin
               if (op_ff == `FDC_OP_SENSEDRV) begin
                  res_ff[0]  <= st3;                             // [RQ4]
                  res_cnt_ff <= 4'h1;
                  state_ff   <= FD_RESULT;
               end else if (cyl_ff[sel] == target_ff && step_cnt_ff == 16'h0) begin
                  state_ff <= FD_IDLE;                           // [RQ2]
               end
            end
            FD_RESULT: begin
               // a write here breaks host ordering; it is ignored
               if (fifo_rd) begin                                // [RQ22]
                  res_idx_ff <= res_idx_ff + 4'h1;
                  if (res_idx_ff + 4'h1 == res_cnt_ff) begin
                     state_ff <= FD_IDLE;
                  end
               end
            end
            default: state_ff <= FD_IDLE;
         endcase
      end
   end

   // head stepping: one low pulse per cylinder, then a settle gap
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         step_cnt_ff <= 16'h0;
         step_n_ff   <= 1'b1;
         dir_ff      <= 1'b0;
         head_n_ff   <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            cyl_ff[i] <= `FDC_RESET_BYTE;
         end
      end else if (state_ff == FD_EXEC && op_ff == `FDC_OP_SEEK) begin
         head_n_ff <= ~drvsel_ff[`FDC_HDS_BIT];
         if (step_cnt_ff != 16'h0) begin
            step_cnt_ff <= step_cnt_ff - 16'h1;
            if (step_cnt_ff == 16'(SETTLE_CYC)) begin
               step_n_ff <= 1'b1;
            end
         end else if (cyl_ff[sel] != target_ff) begin
            dir_ff      <= (target_ff > cyl_ff[sel]);            // [RQ2]
            step_n_ff   <= 1'b0;
            // pin stays low while the count is at or above SETTLE_CYC: STEP_CYC cycles
            step_cnt_ff <= 16'(STEP_CYC + SETTLE_CYC - 1);
            if (target_ff > cyl_ff[sel]) begin
               cyl_ff[sel] <= cyl_ff[sel] + 8'h1;
            end else begin
               cyl_ff[sel] <= cyl_ff[sel] - 8'h1;
            end
         end
      end
   end

   // seek-end status and interrupt; writing the sense interrupt opcode clears it
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         st0_ff <= `FDC_RESET_BYTE;
         irq_ff <= 1'b0;
      end else if (state_ff == FD_EXEC && op_ff == `FDC_OP_SEEK
                   && cyl_ff[sel] == target_ff && step_cnt_ff == 16'h0) begin
         st0_ff <= `FDC_ST0_SEEKEND | {5'h0, drvsel_ff[2:0]};
         irq_ff <= 1'b1;                                         // set wins over clear
      end else if (state_ff == FD_IDLE && fifo_wr && WDATA == `FDC_OP_SENSEINT) begin
         irq_ff <= 1'b0;
      end
   end

   // software registers: output, tape, status mode
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         dor_ff  <= `FDC_RESET_BYTE;
         tape_ff <= `FDC_RESET_BYTE;
         mode_ff <= 8'h01;
      end else if (WR) begin
         if (ADDR == `FDC_OFS_DOR) dor_ff <= WDATA;              // [RQ6]
         if (ADDR == `FDC_OFS_TAPE) tape_ff <= {6'h0, WDATA[1:0]};
         if (ADDR == `FDC_OFS_MODE) mode_ff <= {7'h0, WDATA[0]};
      end
   end

   // edge toggles and latches of drive signals
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         wd_prev_ff <= 1'b1;
         rd_prev_ff <= 1'b1;
         we_prev_ff <= 1'b1;
         wd_tog_ff  <= 1'b0;
         rd_tog_ff  <= 1'b0;
         wd_latch_ff <= 1'b1;
         rd_latch_ff <= 1'b1;
         we_latch_ff <= 1'b1;
         step_latch_ff <= 1'b1;
      end else begin
         wd_prev_ff <= wdn_s;
         rd_prev_ff <= rdn_s;
         we_prev_ff <= wen_s;
         if (wdn_s && !wd_prev_ff) begin
            wd_tog_ff   <= ~wd_tog_ff;                           // [RQ17]
            wd_latch_ff <= wdn_s;                                // [RQ20]
         end
         if (rdn_s && !rd_prev_ff) rd_tog_ff <= ~rd_tog_ff;      // [RQ17]
         // read and write gate latches catch the active level until a status B read; the step latch until a status A read
         if (!rdn_s) rd_latch_ff <= 1'b0;
         else if (RD && ADDR == `FDC_OFS_STB) rd_latch_ff <= 1'b1;
         if (!wen_s) we_latch_ff <= 1'b0;
         else if (RD && ADDR == `FDC_OFS_STB) we_latch_ff <= 1'b1;
         if (!step_n_ff) step_latch_ff <= 1'b0;                  // [RQ13]
         else if (RD && ADDR == `FDC_OFS_STA) step_latch_ff <= 1'b1;
      end
   end

   wire fdcmd_byte_t sta_full = {irq_ff, second_drive_present_n_s, ~step_n_ff, trk0_s,          // [RQ7] [RQ8] [RQ9] [RQ10]
                                 ~head_n_ff, idx_s, wp_s, dir_ff};             // [RQ11] [RQ12]
   wire fdcmd_byte_t sta_red  = {irq_ff, drq_s, ~step_latch_ff, ~trk0_s,      // [RQ13] [RQ14]
                                 head_n_ff, ~idx_s, ~wp_s, ~dir_ff};           // [RQ15]
   wire fdcmd_byte_t stb_full = {2'b11, dor_ff[0], wd_tog_ff, rd_tog_ff,      // [RQ16] [RQ17]
                                 ~wen_s, ~MOTOR_ON_B_N, ~MOTOR_ON_A_N};        // [RQ18]
   wire fdcmd_byte_t stb_red  = {second_drive_present_n_s, pick_n[1], pick_n[0], ~wd_latch_ff,  // [RQ8] [RQ19]
                                 ~rd_latch_ff, ~we_latch_ff,                   // [RQ20]
                                 pick_n[3], pick_n[2]};                        // [RQ21]
   wire fdcmd_byte_t msr = {state_ff != FD_EXEC, state_ff == FD_RESULT, 1'b0,
                            state_ff != FD_IDLE, 4'h0};

   // read port, data valid the cycle after the strobe
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rdata_ff <= `FDC_RESET_BYTE;
      end else if (RD) begin
         unique case (ADDR)                                      // [RQ6]
            `FDC_OFS_STA:  rdata_ff <= full_mode ? sta_full : sta_red;
            `FDC_OFS_STB:  rdata_ff <= full_mode ? stb_full : stb_red;
            `FDC_OFS_TAPE: rdata_ff <= tape_ff;
            `FDC_OFS_MSR:  rdata_ff <= msr;
            `FDC_OFS_FIFO: rdata_ff <= (state_ff == FD_RESULT) ? res_ff[res_idx_ff] : 8'h00;
            `FDC_OFS_MODE: rdata_ff <= mode_ff;
            `FDC_OFS_DIR:  rdata_ff <= 8'h7f;
            default:       rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign RDATA         = rdata_ff;
   assign STEP_N        = step_n_ff;
   assign DIR_IN        = dir_ff;
   assign HEAD_N        = head_n_ff;
   assign MOTOR_ON_A_N  = ~dor_ff[`FDC_DOR_MOTA];
   assign MOTOR_ON_B_N  = ~dor_ff[`FDC_DOR_MOTB];
   assign UNIT_PICK_A_N = pick_n[0];
   assign UNIT_PICK_B_N = pick_n[1];
   assign UNIT_PICK_C_N = pick_n[2];
   assign UNIT_PICK_D_N = pick_n[3];
   assign IRQ           = irq_ff;
endmodule : fdcmd_top

// ---- dv/fdcmd_monitor.sv ----
// concurrent checks on the port behaviour of the floppy command block
`include "fdcmd_regs.svh"
module fdcmd_monitor #(
   parameter int STEP_NS    = 1000,
   parameter int SETTLE_CYC = 4
) (
   input wire logic                   MCLK,
   input wire logic                   SRST,
   input wire logic [2:0]             ADDR,
   input wire fdcmd_pkg::fdcmd_byte_t WDATA,
   input wire logic                   WR,
   input wire logic                   RD,
   input wire fdcmd_pkg::fdcmd_byte_t RDATA,
   input wire logic                   STEP_N,
   input wire logic                   DIR_IN,
   input wire logic                   HEAD_N,
   input wire logic                   MOTOR_ON_A_N,
   input wire logic                   MOTOR_ON_B_N,
   input wire logic                   UNIT_PICK_A_N,
   input wire logic                   UNIT_PICK_B_N,
   input wire logic                   UNIT_PICK_C_N,
   input wire logic                   UNIT_PICK_D_N,
   input wire logic                   IRQ
);
   timeunit 1ns;
   timeprecision 100ps;
   import fdcmd_pkg::*;
   localparam int STEP_CYC = STEP_NS / 10;
   logic        mode_ff;
   logic [15:0] low_cnt_ff;
   logic [15:0] high_cnt_ff;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   always_ff @(posedge MCLK) begin
      if (SRST) mode_ff <= 1'b1;
      else if (WR && ADDR == `FDC_OFS_MODE) mode_ff <= WDATA[0];
   end
   // high count starts saturated so the first step after reset is not flagged
   always_ff @(posedge MCLK) begin
      if (SRST) low_cnt_ff <= 16'h0000;
      else low_cnt_ff <= STEP_N ? 16'h0000 : low_cnt_ff + 16'h0001;
   end
   always_ff @(posedge MCLK) begin
      if (SRST || !STEP_N) high_cnt_ff <= SRST ? 16'hffff : 16'h0000;
      else if (high_cnt_ff != 16'hffff) high_cnt_ff <= high_cnt_ff + 16'h0001;
   end
   a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not zero outside a read answer");
   a_step_width: assert property ($rose(STEP_N) |-> low_cnt_ff == 16'(STEP_CYC))
      else $error("step pulse width wrong");
   a_step_settle: assert property ($fell(STEP_N) |-> high_cnt_ff >= 16'(SETTLE_CYC))
      else $error("step pulses too close");
   a_sta_irq_bit: assert property (RD && ADDR == `FDC_OFS_STA |=> RDATA[7] == $past(IRQ))
      else $error("status A bit 7 differs from interrupt");
   a_sta_head_dir: assert property (RD && ADDR == `FDC_OFS_STA && mode_ff
      |=> {RDATA[3], RDATA[0]} == {!$past(HEAD_N), $past(DIR_IN)})
      else $error("status A head or direction wrong");
   a_stb_motor: assert property (RD && ADDR == `FDC_OFS_STB && mode_ff
      |=> RDATA[1:0] == ~$past({MOTOR_ON_B_N, MOTOR_ON_A_N}))
      else $error("status B motor bits wrong");
   a_stb_select: assert property (RD && ADDR == `FDC_OFS_STB && !mode_ff
      |=> {RDATA[6:5], RDATA[1:0]} ==
          $past({UNIT_PICK_B_N, UNIT_PICK_A_N, UNIT_PICK_D_N, UNIT_PICK_C_N}))
      else $error("status B select bits wrong");
   a_irq_clear: assert property (WR && ADDR == `FDC_OFS_FIFO && WDATA == `FDC_OP_SENSEINT
      && IRQ |=> !IRQ)
      else $error("interrupt not cleared by sense interrupt");
   a_dor_motor: assert property (WR && ADDR == `FDC_OFS_DOR
      |=> {MOTOR_ON_B_N, MOTOR_ON_A_N} == ~$past(WDATA[5:4]))
      else $error("motor outputs do not follow output register");
   a_dor_pick: assert property (WR && ADDR == `FDC_OFS_DOR |=>
      {UNIT_PICK_D_N, UNIT_PICK_C_N, UNIT_PICK_B_N, UNIT_PICK_A_N} ==
      ~(4'h1 << $past(WDATA[1:0])))
      else $error("select outputs do not follow output register");
   c_step: cover property ($fell(STEP_N));
   c_irq: cover property ($rose(IRQ));
   c_reduced_b: cover property (RD && ADDR == `FDC_OFS_STB && !mode_ff);
endmodule : fdcmd_monitor
bind fdcmd_top fdcmd_monitor #(.STEP_NS(STEP_NS), .SETTLE_CYC(SETTLE_CYC)) mon_u (
   .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .STEP_N(STEP_N), .DIR_IN(DIR_IN), .HEAD_N(HEAD_N), .MOTOR_ON_A_N(MOTOR_ON_A_N),
   .MOTOR_ON_B_N(MOTOR_ON_B_N), .UNIT_PICK_A_N(UNIT_PICK_A_N), .UNIT_PICK_B_N(UNIT_PICK_B_N),
   .UNIT_PICK_C_N(UNIT_PICK_C_N), .UNIT_PICK_D_N(UNIT_PICK_D_N), .IRQ(IRQ));

// ---- dv/fdcmd_drive.sv ----
// behavioural floppy drive: follows step pulses and drives the sense lines
module fdcmd_drive (
   input wire logic STEP_N,
   input wire logic DIR_IN,
   input wire logic wp_c,
   input wire logic sd_c,
   input wire logic idx_c,
   output logic     TRACK_ZERO_N,
   output logic     INDEX_N,
   output logic     WRITE_PROT_N,
   output logic     SECOND_DRIVE_PRESENT_N,
   output int       cyl
);
   timeunit 1ns;
   timeprecision 100ps;
   initial cyl = 0;
   // stepping on the falling edge avoids a false step when the pin leaves x at reset
   always @(negedge STEP_N) begin
      // direction changes in the same step as the pulse edge; look a moment later
      #1;
      if (DIR_IN === 1'b1) cyl = cyl + 1;
      else if (cyl > 0) cyl = cyl - 1;
   end
   assign TRACK_ZERO_N = (cyl != 0);
   assign INDEX_N = idx_c;
   assign WRITE_PROT_N = wp_c;
   assign SECOND_DRIVE_PRESENT_N = sd_c;
endmodule : fdcmd_drive

// ---- dv/tb_floppy_cmd_and_pin_status.sv ----
// self-checking bench for the floppy command block and its pin status registers
module tb_floppy_cmd_and_pin_status;
   timeunit 1ns;
   timeprecision 100ps;
   import fdcmd_pkg::*;
   logic MCLK = 1'b0, SRST, WR, RD, READ_STREAM_N, DMA_REQ, WRITE_STREAM_N, WRITE_GATE_N;
   logic TRACK_ZERO_N, INDEX_N, WRITE_PROT_N, SECOND_DRIVE_PRESENT_N, STEP_N, DIR_IN, HEAD_N;
   logic MOTOR_ON_A_N, MOTOR_ON_B_N, UNIT_PICK_A_N, UNIT_PICK_B_N, UNIT_PICK_C_N, UNIT_PICK_D_N;
   logic IRQ, wp_c, sd_c, idx_c, rd_seen, wpar = 1'b0, rpar = 1'b0, head, dir, wg_old = 1'b1;
   logic [2:0]   ADDR;
   fdcmd_byte_t  WDATA, RDATA, dor, op;
   logic [3:0]   pick_n;
   logic [15:0]  exp_q[$];
   int failures = 0, samples_checked = 0, cycles = 0, cyl;
   always #5 MCLK = ~MCLK;
   fdcmd_top #(.STEP_NS(20)) dut_u (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .TRACK_ZERO_N(TRACK_ZERO_N), .INDEX_N(INDEX_N),
      .WRITE_PROT_N(WRITE_PROT_N), .READ_STREAM_N(READ_STREAM_N),
      .SECOND_DRIVE_PRESENT_N(SECOND_DRIVE_PRESENT_N), .DMA_REQ(DMA_REQ),
      .WRITE_STREAM_N(WRITE_STREAM_N), .WRITE_GATE_N(WRITE_GATE_N), .STEP_N(STEP_N),
      .DIR_IN(DIR_IN), .HEAD_N(HEAD_N), .MOTOR_ON_A_N(MOTOR_ON_A_N),
      .MOTOR_ON_B_N(MOTOR_ON_B_N), .UNIT_PICK_A_N(UNIT_PICK_A_N),
      .UNIT_PICK_B_N(UNIT_PICK_B_N), .UNIT_PICK_C_N(UNIT_PICK_C_N),
      .UNIT_PICK_D_N(UNIT_PICK_D_N), .IRQ(IRQ));
   fdcmd_drive drv_u (.STEP_N(STEP_N), .DIR_IN(DIR_IN), .wp_c(wp_c), .sd_c(sd_c),
      .idx_c(idx_c), .TRACK_ZERO_N(TRACK_ZERO_N), .INDEX_N(INDEX_N),
      .WRITE_PROT_N(WRITE_PROT_N), .SECOND_DRIVE_PRESENT_N(SECOND_DRIVE_PRESENT_N),
      .cyl(cyl));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task stop_test;
      $display("compared %0d, mismatched %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task wr(input logic [2:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      RD <= 1'b0;
      @(posedge MCLK);
   endtask : wr
   // masked expectation; the answer is compared by the watcher below
   task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({m, e & m});
      ADDR <= a;
      RD <= 1'b1;
      WR <= 1'b0;
      @(posedge MCLK);
   endtask : rd
   task idle(input int n);
      WR <= 1'b0;
      RD <= 1'b0;
      repeat (n) @(posedge MCLK);
   endtask : idle
   task seek(input logic [7:0] hd, input logic [7:0] c);
      int n;
      n = 0;
      wr(3'h5, 8'h0f);
      wr(3'h5, hd);
      wr(3'h5, c);
      idle(1);
      while (IRQ !== 1'b1 && n < 500) begin
         idle(1);
         n++;
      end
      chk({cyl[7:0], HEAD_N, DIR_IN}, {c, ~head, dir});
      // every result byte is taken before the next opcode
      wr(3'h5, 8'h08);
      rd(3'h5, 8'h20 | {5'h00, hd[2:0]}, 8'hff);
      rd(3'h5, c, 8'hff);
      idle(1);
      chk(IRQ, 1'b0);
   endtask : seek
   always @(posedge MCLK) rd_seen <= RD;
   always @(negedge MCLK) begin
      if (rd_seen && exp_q.size() > 0) begin
         logic [15:0] e;
         e = exp_q.pop_front();
         chk(RDATA & e[15:8], e[7:0]);
      end
   end
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      SRST <= 1'b1; WR <= 1'b0; RD <= 1'b0; ADDR <= 3'h0; WDATA <= 8'h00;
      READ_STREAM_N <= 1'b1; WRITE_STREAM_N <= 1'b1; WRITE_GATE_N <= 1'b1; DMA_REQ <= 1'b0;
      wp_c <= 1'b0; sd_c <= 1'b1; idx_c <= 1'b1;
      void'($urandom(20));
      repeat (3) @(posedge MCLK);
      SRST <= 1'b0;
      idle(8);
      chk({STEP_N, IRQ, UNIT_PICK_A_N, MOTOR_ON_A_N}, 4'b1001);
      repeat (8) begin
         op = 8'($urandom);
         if (op inside {8'h08, 8'h0f, 8'h0e, 8'h04}) op = 8'h00;
         wr(3'h5, op);
         rd(3'h5, 8'h80, 8'hff);
      end
      rd(3'h5, 8'h00, 8'hff);
      wr(3'h5, 8'h04);
      wr(3'h5, 8'h00);
      idle(1);
      rd(3'h5, 8'hd8, 8'hff);
      head = 1'b0;
      dir = 1'b1;
      seek(8'h00, 8'h03);
      wr(3'h5, 8'h0e);
      for (int i = 0; i < 10; i++) rd(3'h5, (i == 0) ? 8'h03 : 8'h00, 8'hff);
      head = 1'b1;
      dir = 1'b0;
      seek(8'h04, 8'h01);
      op = 8'($urandom);
      wr(3'h3, op);
      rd(3'h3, {6'h00, op[1:0]}, 8'hff);
      rd(3'h2, 8'h00, 8'hff);
      rd(3'h7, 8'h7f, 8'hff);
      rd(3'h4, 8'h80, 8'hd0);
      for (int m = 1; m >= 0; m--) begin
         wr(3'h6, {7'h00, 1'(m)});
         repeat (4) begin
            dor = {2'b00, 2'($urandom), 2'b11, 2'($urandom)};
            pick_n = ~(4'h1 << dor[1:0]);
            wr(3'h2, dor);
            {wp_c, sd_c, idx_c, DMA_REQ, WRITE_GATE_N} <= 5'($urandom);
            READ_STREAM_N <= 1'b0;
            idle(4);
            READ_STREAM_N <= 1'b1;
            rpar = ~rpar;
            if ($urandom % 2) begin
               WRITE_STREAM_N <= 1'b0;
               idle(4);
               WRITE_STREAM_N <= 1'b1;
               wpar = ~wpar;
            end
            idle(8);
            chk({MOTOR_ON_B_N, MOTOR_ON_A_N, UNIT_PICK_D_N, UNIT_PICK_C_N, UNIT_PICK_B_N,
                 UNIT_PICK_A_N}, {~dor[5:4], pick_n});
            if (m == 1) begin
               rd(3'h0, {1'b0, sd_c, 1'b0, TRACK_ZERO_N, head, idx_c, wp_c, dir}, 8'hff);
               rd(3'h1, {2'b00, dor[0], wpar, rpar, ~WRITE_GATE_N, dor[5:4]}, 8'h3f);
            end else begin
               rd(3'h0, {1'b0, DMA_REQ, 1'b0, ~TRACK_ZERO_N, ~head, ~idx_c, ~wp_c, ~dir},
                  8'hff);
               rd(3'h1, {sd_c, pick_n[1:0], 2'b01, ~(wg_old & WRITE_GATE_N), pick_n[3:2]},
                  8'hff);
            end
            wg_old = WRITE_GATE_N;
         end
      end
      idle(3);
      stop_test();
   end
endmodule : tb_floppy_cmd_and_pin_status
